// *** cpsc_core_model.sv ***
// Core and peripheral stand-in: request levels out, clock ticks counted in.
// Assumes the bench sets want just after a clock edge.
`timescale 1ns/1ns

module cpsc_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire cpsc_pkg::cpsc_core_s want,
  input wire cpsc_pkg::cpsc_clk_s clks,
  output cpsc_pkg::cpsc_core_s core,
  output logic [15:0] cpu_cnt,
  output logic [15:0] pre_cnt,
  output logic [15:0] p0_cnt,
  output logic [15:0] p1_cnt
);
  always_ff @(posedge clk) begin
    // Requests are levels, held until the bench drops them
    core <= rst ? '0 : want;
    if (rst || clr) begin
      cpu_cnt <= 16'h0;
      pre_cnt <= 16'h0;
      p0_cnt <= 16'h0;
      p1_cnt <= 16'h0;
    end else begin
      cpu_cnt <= cpu_cnt + {15'h0, clks.cpu_tick};
      pre_cnt <= pre_cnt + {15'h0, clks.prescaler_in_tick};
      p0_cnt <= p0_cnt + {15'h0, clks.periph_tick[0]};
      p1_cnt <= p1_cnt + {15'h0, clks.periph_tick[1]};
    end
  end
endmodule

// *** cpsc_pkg.sv ***
// Types of the clock and standby controller.
// Assumes cpsc_regs.svh supplies the register constants; the mode codes are fixed here.
package cpsc_pkg;

  typedef enum logic [5:0] {
    MODE_NORMAL = 6'h01,
    MODE_IDLE_HALT = 6'h02,
    MODE_IDLE_DOZE = 6'h04,
    MODE_SLEEP = 6'h08,
    MODE_STOP = 6'h10,
    MODE_WARM = 6'h20
  } cpsc_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cpsc_bus_s;

  typedef struct packed {
    logic halt_req;
    logic doze_req;
    logic wake_req;
    logic dma_req;
  } cpsc_core_s;

  typedef struct packed {
    logic sys_tick;
    logic cpu_tick;
    logic prescaler_in_tick;
    logic [7:0] periph_tick;
    logic low_speed_run;
    logic high_speed_osc_en;
    logic pll_run;
    logic dma_grant;
  } cpsc_clk_s;

  typedef struct packed {
    cpsc_mode_e mode;
    logic strap_done;
    logic pll_on;
    logic [16:0] timer;
    logic warm_busy;
    logic lock_pend;
    logic [1:0] osc_ph;
    logic [1:0] gear_act;
    logic [1:0] gear_req;
    logic [1:0] gear_wait;
    logic [2:0] gdiv;
    logic [1:0] pre_act;
    logic [1:0] pre_sel;
    logic [1:0] pdiv;
    logic src_sel;
    logic [1:0] stby_sel;
    logic [1:0] wup_sel;
    logic [1:0] lup_sel;
    logic [7:0] idle_run;
    logic [31:0] rdata;
    cpsc_clk_s clk_out;
  } cpsc_state_s;

endpackage

// *** cpsc_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the clock and standby controller.
// Assumes a plain byte-addressed register port with 8-bit addresses and 32-bit data.
`ifndef CPSC_REGS_SVH
`define CPSC_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define CPSC_OFS_SYS_CTRL_0 8'h00
`define CPSC_OFS_SYS_CTRL_1 8'h04
`define CPSC_OFS_SYS_CTRL_2 8'h08
`define CPSC_OFS_SYS_CTRL_3 8'h0c
`define CPSC_OFS_IDLE_RUN 8'h10
`define CPSC_OFS_STATUS 8'h14

// ****************************************
// Field positions
// ****************************************
`define CPSC_PRE_LSB 0
`define CPSC_WUP_DONE_BIT 4
`define CPSC_WUP_START_BIT 5
`define CPSC_GEAR_LSB 0
`define CPSC_SRC_BIT 2
`define CPSC_STBY_LSB 0
`define CPSC_WUPT_LSB 4
`define CPSC_LUPT_LSB 0
`define CPSC_LOCK_BIT 4
`define CPSC_PLL_ON_BIT 5

// ****************************************
// Reset values
// ****************************************
`define CPSC_RST_GEAR 2'h3
`define CPSC_RST_PRE 2'h0
`define CPSC_RST_SRC 1'h0
`define CPSC_RST_STBY 2'h0
`define CPSC_RST_WUPT 2'h2
`define CPSC_RST_LUPT 2'h3
`define CPSC_RST_IDLE_RUN 8'h00

// ****************************************
// Timing
// ****************************************
`define CPSC_CLK_PERIOD_NS 100
`define CPSC_GEAR_LAT_NS 300
`define CPSC_GEAR_LAT_CYC ((`CPSC_GEAR_LAT_NS + `CPSC_CLK_PERIOD_NS - 1) / `CPSC_CLK_PERIOD_NS)
`define CPSC_PLL_MULT 4

`endif

// *** cpsc_tb_top.sv ***
// Bench of the clock and standby controller: register tasks and table tests.
// Assumes cpsc_core_model drives core requests and counts tick outputs.
`timescale 1ns/1ns

module cpsc_tb_top;
  logic clk;
  logic rst;
  logic pll_disable_pin;
  logic clr;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [2:0] outs;
  logic [15:0] cpu_cnt, pre_cnt, p0_cnt, p1_cnt;
  int failures;
  int checked;
  int i;
  int k;
  cpsc_pkg::cpsc_bus_s bus;
  cpsc_pkg::cpsc_core_s want;
  cpsc_pkg::cpsc_core_s core;
  cpsc_pkg::cpsc_clk_s clks;
  // Nibbles: gear, source, prescaler select, then ticks expected in 16 cycles
  logic [19:0] ptab [6] = '{20'h00004, 20'h00108, 20'h00210, 20'h11210, 20'h10208, 20'h11004};
  // Standby field, mode, grant/osc/slow, run-peripheral ticks; doze first
  logic [23:0] stab [4] = '{24'h104708, 24'h002308, 24'h208100, 24'h110000};

  assign outs = {clks.dma_grant, clks.high_speed_osc_en, clks.low_speed_run};

  cpsc_top dut_u (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pll_disable_pin(pll_disable_pin),
    .core(core), .clks(clks));
  cpsc_core_model core_u (.clk(clk), .rst(rst), .clr(clr), .want(want), .clks(clks), .core(core),
    .cpu_cnt(cpu_cnt), .pre_cnt(pre_cnt), .p0_cnt(p0_cnt), .p1_cnt(p1_cnt));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ********
  // Tasks
  // ********
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic count(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic pin);
    @(posedge clk);
    rst <= 1'b1;
    pll_disable_pin <= pin;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    failures++;
    complete_run();
  end

  // ********
  // Tests
  // ********
  initial begin
    rst = 1'b1;
    pll_disable_pin = 1'b1;
    clr = 1'b0;
    bus = '0;
    want = '0;
    failures = 0;
    checked = 0;
    do_reset(1'b1);
    rd(8'h00);
    check("prescaler sel", 32'h0, v & 32'h3);
    rd(8'h04);
    check("gear and source", 32'h3, v & 32'h7);
    rd(8'h08);
    check("warm-up sel", 32'h20, v & 32'h30);
    rd(8'h0c);
    check("lock-up sel, flag, pll", 32'h33, v & 32'h33);
    rd(8'h20);
    check("unmapped read", 32'h0, v);
    // Shortest warm-up, lock-up of 2^10 oscillator ticks, about 4096 cycles
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h0);
    rd(8'h0c);
    check("lock pending", 32'h10, v & 32'h10);
    for (i = 0; i < 3000 && v[4] !== 1'b0; i++)
      rd(8'h0c);
    check("lock wait", 32'h1, {31'h0, i > 1950 && i < 2100});
    rd(8'h00);
    check("warm-up done", 32'h10, v & 32'h10);
    count(80);
    check("cpu ticks gear 3", 32'd10, {16'h0, cpu_cnt});
    check("periph ticks gear 3", 32'd10, {16'h0, p0_cnt});
    wr(8'h04, 32'h0);
    rd(8'h14);
    check("gear before latency", 32'h300, v & 32'h300);
    wr(8'h20, 32'hffffffff);
    repeat (20) @(posedge clk);
    rd(8'h14);
    check("gear after latency", 32'h0, v & 32'h300);
    for (k = 0; k < 6; k++) begin
      wr(8'h04, {29'h0, ptab[k][12], ptab[k][17:16]});
      wr(8'h00, {30'h0, ptab[k][9:8]});
      repeat (30) @(posedge clk);
      count(16);
      check("prescaler ticks", {24'h0, ptab[k][7:0]}, {16'h0, pre_cnt});
    end
    wr(8'h10, 32'h1);
    for (k = 0; k < 4; k++) begin
      wr(8'h08, {30'h0, stab[k][21:20]});
      @(posedge clk);
      want.doze_req <= (k == 0);
      want.halt_req <= (k != 0);
      want.dma_req <= 1'b1;
      repeat (6) @(posedge clk);
      want.doze_req <= 1'b0;
      want.halt_req <= 1'b0;
      rd(8'h14);
      check("standby mode", {24'h0, stab[k][19:12]}, v & 32'h3f);
      check("grant osc slow", {29'h0, stab[k][10:8]}, {29'h0, outs});
      count(16);
      check("cpu ticks", 32'h0, {16'h0, cpu_cnt});
      check("run periph ticks", {24'h0, stab[k][7:0]}, {16'h0, p0_cnt});
      check("stopped periph ticks", 32'h0, {16'h0, p1_cnt});
      want <= '0;
      @(posedge clk);
      want.wake_req <= 1'b1;
      repeat (4) @(posedge clk);
      want.wake_req <= 1'b0;
      for (i = 0; i < 100 && v[5:0] !== 6'h01; i++)
        rd(8'h14);
      check("mode after wake", 32'h1, v & 32'h3f);
    end
    // Second reset in mid-run, strap low this time
    do_reset(1'b0);
    rd(8'h0c);
    check("pll off, lock-up sel", 32'h3, v & 32'h23);
    check("pll run", 32'h0, {31'h0, clks.pll_run});
    rd(8'h04);
    check("gear after reset", 32'h3, v & 32'h7);
    wr(8'h04, 32'h4);
    wr(8'h00, 32'h2);
    repeat (30) @(posedge clk);
    count(16);
    check("raw oscillator ticks", 32'h4, {16'h0, pre_cnt});
    complete_run();
  end
endmodule

bind cpsc_top cpsc_top_assertions chk_u (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .pll_disable_pin(pll_disable_pin), .core(core), .clks(clks));

// *** cpsc_top.sv ***
// Clock gear, peripheral prescaler, PLL lock timer and standby mode control.
// Assumes clk runs at the PLL output rate; oscillator and gated clocks are given as one-cycle ticks.
//
// Overview of operation
// (RL1) Peripheral base: gear clock or high-speed clock
// (RL2) Prescaler input divides base by 4, 2, 1
// (RL3) Reset: gear clock base, divide by 4
// (RL4) PLL output is four times oscillator rate
// (RL5) Reset halts PLL; pin high enables it
// (RL6) Pin low: PLL off, raw oscillator clock
// (RL7) One timer counts warm-up and lock-up
// (RL8) Software keeps lock-up time not below warm-up
// (RL9) Lock-up selection resets to 2^16 cycles
// (RL10) Lock flag 1 while pending, 0 after
// (RL11) Lock flag undefined while PLL unused
// (RL12) Gear write takes effect after several cycles
// (RL13) Software adds dummy write after gear change
// (RL14) Software keeps prescaler outputs below fsys/2
// (RL15) Halt enters IDLE, SLEEP or STOP by field
// (RL16) Doze always enters IDLE
// (RL17) IDLE stops CPU; peripherals per run bit
// (RL18) Halt IDLE holds bus, ignores DMA
// (RL19) Doze IDLE grants bus to requesters
// (RL20) SLEEP keeps only low-speed blocks running; the code keeps sys_tick running in SLEEP
// (RL21) STOP halts everything; the code keeps sys_tick running in STOP
// (RL22) NORMAL clocks core and peripherals fully
// (RL23) Reset sets gear 11, divide by eight
// (RL24) Reset selects 2^14 warm-up time
// (RL25) Gear and prescaler change at clock boundary
// (RL26) IDLE gates peripherals set to stop
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "cpsc_regs.svh"

module cpsc_top (
  input wire logic clk,
  input wire logic rst,
  input wire cpsc_pkg::cpsc_bus_s bus,
  output logic [31:0] rdata,
  input wire logic pll_disable_pin,
  input wire cpsc_pkg::cpsc_core_s core,
  output cpsc_pkg::cpsc_clk_s clks
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [16:0] wup_target(input logic [1:0] sel);
    unique case (sel)
      2'h0: wup_target = 17'h00004;
      2'h1: wup_target = 17'h00100;
      2'h2: wup_target = 17'h04000;
      2'h3: wup_target = 17'h10000;
    endcase
  endfunction

  // Oscillator runs in every mode but SLEEP and STOP
  function automatic logic osc_live(input cpsc_pkg::cpsc_mode_e m);
    osc_live = (m != cpsc_pkg::MODE_SLEEP) && (m != cpsc_pkg::MODE_STOP);
  endfunction

  function automatic logic [16:0] lup_target(input logic [1:0] sel);
    unique case (sel)
      2'h0: lup_target = 17'h00400;
      2'h1: lup_target = 17'h01000;
      2'h2: lup_target = 17'h04000;
      2'h3: lup_target = 17'h10000;
    endcase
  endfunction

  // Gear code n divides by 2^n
  function automatic logic [2:0] gear_last(input logic [1:0] g);
    unique case (g)
      2'h0: gear_last = 3'h0;
      2'h1: gear_last = 3'h1;
      2'h2: gear_last = 3'h3;
      2'h3: gear_last = 3'h7;
    endcase
  endfunction

  // 00 divides by 4, 01 by 2, others pass through
  function automatic logic [1:0] pre_last(input logic [1:0] p);
    unique case (p)
      2'h0: pre_last = 2'h3;
      2'h1: pre_last = 2'h1;
      2'h2: pre_last = 2'h0;
      2'h3: pre_last = 2'h0;
    endcase
  endfunction

  cpsc_pkg::cpsc_state_s st_ff;
  cpsc_pkg::cpsc_state_s nxt_st;

  logic osc_tick;
  logic hs_tick;
  logic gear_edge;
  logic base_tick;
  logic pre_edge;
  logic normal;
  logic idle;
  logic [16:0] warm_t;
  logic [16:0] lock_t;
  logic [7:0] nxt_periph;

  // ****************************************
  // Clock tree
  // ****************************************
  always_comb begin
    osc_tick = (st_ff.osc_ph == 2'h3);
    // Unmultiplied oscillator is one clk in four
    hs_tick = st_ff.pll_on ? 1'b1 : osc_tick; // RL4 RL6
    gear_edge = hs_tick && (st_ff.gdiv == gear_last(st_ff.gear_act));
    base_tick = st_ff.src_sel ? hs_tick : gear_edge; // RL1
    pre_edge = base_tick && (st_ff.pdiv == pre_last(st_ff.pre_act)); // RL2
  end

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb begin
    normal = (st_ff.mode == cpsc_pkg::MODE_NORMAL);
    idle = (st_ff.mode == cpsc_pkg::MODE_IDLE_HALT) || (st_ff.mode == cpsc_pkg::MODE_IDLE_DOZE);
  end

  // ****************************************
  // Timer targets
  // ****************************************
  // Lock-up shorter than warm-up is not caught here; software keeps the order
  always_comb begin
    warm_t = wup_target(st_ff.wup_sel);
    lock_t = lup_target(st_ff.lup_sel);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    // ****************************************
    // Defaults
    // ****************************************
    nxt_st = st_ff;
    nxt_st.osc_ph = st_ff.osc_ph + 2'h1;
    nxt_st.rdata = 32'h0;

    // ****************************************
    // Strap capture
    // ****************************************
    // Strap is caught on the first clocked edge after release
    if (!st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.pll_on = pll_disable_pin; // RL5 RL6
      nxt_st.timer = 17'h0;
      nxt_st.warm_busy = 1'b1; // RL24
      nxt_st.lock_pend = pll_disable_pin; // RL10
    end

    // ****************************************
    // Shared timer
    // ****************************************
    // Shared warm-up and lock-up timer, counted in oscillator cycles
    // Frozen while the oscillator is off; a wake restarts it from zero
    if ((st_ff.warm_busy || st_ff.lock_pend) && osc_tick && osc_live(st_ff.mode)) begin
      nxt_st.timer = st_ff.timer + 17'h1; // RL7
      if (st_ff.timer + 17'h1 >= warm_t) begin
        nxt_st.warm_busy = 1'b0;
      end
      if (st_ff.timer + 17'h1 >= lock_t) begin
        nxt_st.lock_pend = 1'b0; // RL10
      end
    end

    // ****************************************
    // Gear divider
    // ****************************************
    // Gear divider; a pending gear waits out its latency, then a boundary
    // A rewrite during the wait restarts the wait
    if (hs_tick) begin
      nxt_st.gdiv = gear_edge ? 3'h0 : st_ff.gdiv + 3'h1;
    end
    if (st_ff.gear_wait != 2'h0) begin
      nxt_st.gear_wait = st_ff.gear_wait - 2'h1; // RL12
    end else if (gear_edge && (st_ff.gear_req != st_ff.gear_act)) begin
      nxt_st.gear_act = st_ff.gear_req; // RL25
    end

    // ****************************************
    // Prescaler
    // ****************************************
    // Prescaler input divider
    // Select is taken only at the wrap, so no short pulse escapes
    if (base_tick) begin
      nxt_st.pdiv = pre_edge ? 2'h0 : st_ff.pdiv + 2'h1;
      if (pre_edge) begin
        nxt_st.pre_act = st_ff.pre_sel; // RL25
      end
    end

    // ****************************************
    // Standby
    // ****************************************
    // Standby mode sequencing
    // Doze is tested first: it wins over halt
    unique case (st_ff.mode)
      cpsc_pkg::MODE_NORMAL: begin
        if (core.doze_req) begin
          nxt_st.mode = cpsc_pkg::MODE_IDLE_DOZE; // RL16
        end else if (core.halt_req) begin
          unique case (st_ff.stby_sel) // RL15
            2'h1: nxt_st.mode = cpsc_pkg::MODE_STOP;
            2'h2: nxt_st.mode = cpsc_pkg::MODE_SLEEP;
            default: nxt_st.mode = cpsc_pkg::MODE_IDLE_HALT;
          endcase
        end
      end
      cpsc_pkg::MODE_IDLE_HALT, cpsc_pkg::MODE_IDLE_DOZE: begin
        if (core.wake_req) begin
          nxt_st.mode = cpsc_pkg::MODE_NORMAL;
        end
      end
      cpsc_pkg::MODE_SLEEP, cpsc_pkg::MODE_STOP: begin
        // High-speed oscillator was off; it must settle again
        if (core.wake_req) begin
          nxt_st.mode = cpsc_pkg::MODE_WARM;
          nxt_st.timer = 17'h0;
          nxt_st.warm_busy = 1'b1;
          nxt_st.lock_pend = st_ff.pll_on;
        end
      end
      cpsc_pkg::MODE_WARM: begin
        if (!st_ff.warm_busy) begin
          nxt_st.mode = cpsc_pkg::MODE_NORMAL;
        end
      end
    endcase

    // ****************************************
    // Register writes
    // ****************************************
    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `CPSC_OFS_SYS_CTRL_0: begin
          nxt_st.pre_sel = bus.wdata[`CPSC_PRE_LSB +: 2];
          // Software restart of warm-up; lock-up restarts with it
          if (bus.wdata[`CPSC_WUP_START_BIT]) begin
            nxt_st.timer = 17'h0;
            nxt_st.warm_busy = 1'b1;
            nxt_st.lock_pend = st_ff.pll_on; // RL10
          end
        end
        `CPSC_OFS_SYS_CTRL_1: begin
          nxt_st.gear_req = bus.wdata[`CPSC_GEAR_LSB +: 2];
          nxt_st.gear_wait = 2'(`CPSC_GEAR_LAT_CYC); // RL12
          nxt_st.src_sel = bus.wdata[`CPSC_SRC_BIT];
        end
        `CPSC_OFS_SYS_CTRL_2: begin
          nxt_st.stby_sel = bus.wdata[`CPSC_STBY_LSB +: 2];
          nxt_st.wup_sel = bus.wdata[`CPSC_WUPT_LSB +: 2];
        end
        `CPSC_OFS_SYS_CTRL_3: begin
          nxt_st.lup_sel = bus.wdata[`CPSC_LUPT_LSB +: 2];
        end
        `CPSC_OFS_IDLE_RUN: begin
          nxt_st.idle_run = bus.wdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Register reads, answered in the next cycle; unmapped reads give zero
    // Status view is read-only; writes there are ignored
    if (bus.rd) begin
      unique case (bus.addr)
        `CPSC_OFS_SYS_CTRL_0: begin
          nxt_st.rdata[`CPSC_PRE_LSB +: 2] = st_ff.pre_sel;
          nxt_st.rdata[`CPSC_WUP_DONE_BIT] = !st_ff.warm_busy;
        end
        `CPSC_OFS_SYS_CTRL_1: begin
          nxt_st.rdata[`CPSC_GEAR_LSB +: 2] = st_ff.gear_req;
          nxt_st.rdata[`CPSC_SRC_BIT] = st_ff.src_sel;
        end
        `CPSC_OFS_SYS_CTRL_2: begin
          nxt_st.rdata[`CPSC_STBY_LSB +: 2] = st_ff.stby_sel;
          nxt_st.rdata[`CPSC_WUPT_LSB +: 2] = st_ff.wup_sel;
        end
        `CPSC_OFS_SYS_CTRL_3: begin
          nxt_st.rdata[`CPSC_LUPT_LSB +: 2] = st_ff.lup_sel;
          // Reads 0 with the PLL unused; software must not rely on it
          nxt_st.rdata[`CPSC_LOCK_BIT] = st_ff.lock_pend; // RL10 RL11
          nxt_st.rdata[`CPSC_PLL_ON_BIT] = st_ff.pll_on;
        end
        `CPSC_OFS_IDLE_RUN: begin
          nxt_st.rdata[7:0] = st_ff.idle_run;
        end
        `CPSC_OFS_STATUS: begin
          nxt_st.rdata[5:0] = st_ff.mode;
          nxt_st.rdata[9:8] = st_ff.gear_act;
          nxt_st.rdata[13:12] = st_ff.pre_act;
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Clock outputs
    // ****************************************
    // Registered clock ticks and enables
    nxt_st.clk_out.sys_tick = gear_edge;
    nxt_st.clk_out.periph_tick = nxt_periph; // RL26 RL17
    nxt_st.clk_out.cpu_tick = gear_edge && normal; // RL22 RL17
    nxt_st.clk_out.prescaler_in_tick = pre_edge && (normal || idle); // RL20 RL21
    nxt_st.clk_out.low_speed_run = (st_ff.mode != cpsc_pkg::MODE_STOP); // RL20 RL21
    nxt_st.clk_out.high_speed_osc_en = osc_live(st_ff.mode);
    nxt_st.clk_out.pll_run = st_ff.pll_on && nxt_st.clk_out.high_speed_osc_en; // RL5
    // Halted core keeps the bus; doze lets DMA in
    nxt_st.clk_out.dma_grant = core.dma_req && (st_ff.mode == cpsc_pkg::MODE_IDLE_DOZE); // RL18 RL19
  end

  // ****************************************
  // Peripheral gates
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_periph
      // IDLE honours each run bit; NORMAL feeds all
      assign nxt_periph[gi] = gear_edge && (normal || (idle && st_ff.idle_run[gi])); // RL26 RL17
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    clks.sys_tick = st_ff.clk_out.sys_tick;
    clks.periph_tick = st_ff.clk_out.periph_tick;
    clks.cpu_tick = st_ff.clk_out.cpu_tick;
    clks.prescaler_in_tick = st_ff.clk_out.prescaler_in_tick;
    clks.low_speed_run = st_ff.clk_out.low_speed_run;
    clks.high_speed_osc_en = st_ff.clk_out.high_speed_osc_en;
    clks.pll_run = st_ff.clk_out.pll_run;
    clks.dma_grant = st_ff.clk_out.dma_grant;
    rdata = st_ff.rdata;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.mode <= cpsc_pkg::MODE_NORMAL;
      st_ff.pll_on <= 1'b0; // RL5
      st_ff.gear_act <= `CPSC_RST_GEAR; // RL23
      st_ff.gear_req <= `CPSC_RST_GEAR; // RL23
      st_ff.pre_act <= `CPSC_RST_PRE; // RL3
      st_ff.pre_sel <= `CPSC_RST_PRE; // RL3
      st_ff.src_sel <= `CPSC_RST_SRC; // RL3
      st_ff.stby_sel <= `CPSC_RST_STBY;
      st_ff.wup_sel <= `CPSC_RST_WUPT; // RL24
      st_ff.lup_sel <= `CPSC_RST_LUPT; // RL9
      st_ff.idle_run <= `CPSC_RST_IDLE_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// *** cpsc_top_assertions.sv ***
// Port checks of the clock and standby controller.
// Assumes a bind onto cpsc_top; one clock, synchronous reset.
`timescale 1ns/1ns

module cpsc_top_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire cpsc_pkg::cpsc_bus_s bus,
  input wire logic [31:0] rdata,
  input wire logic pll_disable_pin,
  input wire cpsc_pkg::cpsc_core_s core,
  input wire cpsc_pkg::cpsc_clk_s clks
);
  logic seen_ff;
  logic strap_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Strap as sampled at the first edge out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_ff <= 1'b0;
      strap_ff <= 1'b0;
    end else if (!seen_ff) begin
      seen_ff <= 1'b1;
      strap_ff <= pll_disable_pin;
    end
  end

  // ********
  // Properties
  // ********
  // Two edges of request, so a warm-up that ends in between is allowed for
  sequence halt_held;
    (core.halt_req && !core.doze_req && !core.wake_req)[*2] ##1 !core.wake_req;
  endsequence
  sequence doze_held;
    (core.doze_req && !core.wake_req)[*2] ##1 !core.wake_req;
  endsequence

  AST_HALT_STOP_CPU: assert property (halt_held |=> !clks.cpu_tick)
    else $error("cpu runs after halt");
  AST_DOZE_STOP_CPU: assert property (doze_held |=> !clks.cpu_tick)
    else $error("cpu runs after doze");
  AST_CPU_IN_SYS: assert property (clks.cpu_tick |-> clks.sys_tick)
    else $error("cpu tick off system tick");
  AST_PERIPH_IN_SYS: assert property (|clks.periph_tick |-> clks.sys_tick)
    else $error("peripheral tick off system tick");
  AST_GRANT_CAUSE: assert property (clks.dma_grant |-> $past(core.dma_req))
    else $error("grant without request");
  AST_GRANT_CPU_IDLE: assert property (clks.dma_grant |-> !clks.cpu_tick)
    else $error("grant while cpu runs");
  AST_SLEEP_QUIET: assert property (!clks.high_speed_osc_en |-> !clks.cpu_tick && clks.periph_tick == 8'h00)
    else $error("ticks with oscillator off");
  AST_STOP_QUIET: assert property (!clks.low_speed_run |-> !clks.high_speed_osc_en && !clks.prescaler_in_tick)
    else $error("activity in stop");
  AST_PLL_NEEDS_OSC: assert property (clks.pll_run |-> clks.high_speed_osc_en)
    else $error("pll runs without oscillator");
  AST_PLL_STRAP_OFF: assert property (seen_ff && !strap_ff |-> !clks.pll_run)
    else $error("pll runs with strap low");
endmodule
